// [src/llec_top.sv]
// Purpose: Loss-of-signal timing, indirect equalizer RAM access and settle qualification.
// Assumes: Bus strobes are synchronous to the clock and active low.
// Notes: Registers are byte wide; unmapped and unused bits read as zero, but reserved config bit 3 reads back as written.
`timescale 1ns/1ns
module llec_top
  import llec_pkg::*;
(
  input wire logic clock, // System clock, 10 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic receive_unit_hold, // Holds all registers except the test forcing bits at reset when high.
  input wire llec_bus_s bus_in, // Host bus strobes, address and write data.
  output logic [7:0] bus_rd_data, // Read data, registered.
  output logic bus_data_oe, // High while the block drives the data bus.
  output logic outputs_hiz, // High while all outputs must float.
  input wire logic pulse_tick, // One-cycle pulse per received pulse interval.
  input wire logic level_below_det, // Level at or below detection threshold.
  input wire logic level_above_clr, // Level at or above clearance threshold.
  input wire logic line_tick, // One-cycle pulse per line-rate clock.
  input wire logic loss_step_up, // Estimator asks for one more loss step.
  input wire logic loss_step_down, // Estimator asks for one less loss step.
  input wire logic test_mode0, // All internal blocks are in test mode 0.
  output logic analog_signal_loss, // Loss of signal state to the device.
  output logic equalizer_settled, // Equalizer settled flag.
  output logic [31:0] eq_coeff, // Equalizer RAM word at the read counter.
  output logic loop_tick // One-cycle pulse per equalizer loop period.
);
  llec_state_s st_reg;
  llec_state_s st_next;
  logic [7:0] test_force_reg;
  logic [31:0] ram_rdata;
  logic [31:0] ram_wdata;
  logic ram_en;
  logic ram_we;
  logic [7:0] ram_addr;
  logic wr_now;
  logic rd_now;
  logic wr_pulse;
  logic rd_pulse;
  logic test_space;
  logic [11:0] assert_target;
  logic [11:0] release_target;
  logic [8:0] div_limit;
  logic [9:0] window;
  logic [8:0] delta;
  logic [7:0] read_mux;
  logic [1:0] data_idx;
  logic loss_rise;

  assign wr_now = !bus_in.chip_select_n && !bus_in.write_strobe_n && bus_in.read_strobe_n;
  assign rd_now = !bus_in.chip_select_n && !bus_in.read_strobe_n && bus_in.write_strobe_n;
  assign wr_pulse = wr_now && !st_reg.wr_prev;
  assign rd_pulse = rd_now && !st_reg.rd_prev;
  assign test_space = bus_in.addr[8];
  assign data_idx = bus_in.addr[1:0];
  assign assert_target = {st_reg.assert_iv, 4'h0} << (LLEC_INTERVAL_UNIT_LOG2 - 4'h4);
  assign release_target = {st_reg.release_iv, 4'h0} << (LLEC_INTERVAL_UNIT_LOG2 - 4'h4);
  assign ram_wdata = st_reg.data;

  // Rate code n stretches the loop period to (n+1) base periods.
  always_comb begin
    div_limit = LLEC_LOOP_BASE_TICKS * ({6'h0, st_reg.config_val[LLEC_CFG_RATE_LSB +: 3]}
      + 9'h001) - 9'h001;
  end

  always_comb begin
    case (st_reg.config_val[LLEC_CFG_WIN_LSB +: 2])
      2'b00: window = LLEC_WIN_32;
      2'b01: window = LLEC_WIN_64;
      2'b10: window = LLEC_WIN_128;
      default: window = LLEC_WIN_256;
    endcase
  end

  assign loop_tick = line_tick && (st_reg.div_cnt == div_limit);

  always_comb begin
    if (st_reg.counter >= st_reg.ref_val) begin
      delta = {1'b0, st_reg.counter - st_reg.ref_val};
    end else begin
      delta = {1'b0, st_reg.ref_val - st_reg.counter};
    end
  end

  always_comb begin
    read_mux = 8'h00;
    if (test_space) begin
      if (bus_in.addr == LLEC_ADDR_TEST_IO && test_mode0) begin
        read_mux = {6'h00, level_above_clr, level_below_det};
      end
    end else if (bus_in.addr >= LLEC_ADDR_DATA0 && bus_in.addr <= LLEC_ADDR_DATA3) begin
      read_mux = st_reg.data[data_idx];
    end else begin
      case (bus_in.addr)
        LLEC_ADDR_STATUS: begin
          read_mux[LLEC_STAT_EVENT_BIT] = st_reg.loss_event;
          read_mux[LLEC_STAT_STATE_BIT] = st_reg.loss_state;
          read_mux[LLEC_STAT_SETTLED_BIT] = st_reg.settled;
        end
        LLEC_ADDR_ASSERT: read_mux = st_reg.assert_iv;
        LLEC_ADDR_RELEASE: read_mux = st_reg.release_iv;
        LLEC_ADDR_POINTER: read_mux = st_reg.pointer;
        LLEC_ADDR_DIR: read_mux[LLEC_DIR_BIT] = st_reg.read_not_write;
        LLEC_ADDR_COUNTER: read_mux = st_reg.counter;
        LLEC_ADDR_CONFIG: read_mux = st_reg.config_val;
        default: read_mux = 8'h00;
      endcase
    end
  end

  always_comb begin
    st_next = st_reg;
    ram_en = 1'b0;
    ram_we = 1'b0;
    ram_addr = st_reg.pointer;
    loss_rise = 1'b0;
    st_next.wr_prev = wr_now;
    st_next.rd_prev = rd_now;
    st_next.ram_load = 1'b0;

    // Loss timing counts only whole consecutive intervals of the wanted level.
    if (pulse_tick) begin
      if (!st_reg.loss_state) begin
        if (level_below_det) begin
          if (st_reg.run_cnt + 12'h001 >= assert_target) begin
            st_next.loss_state = 1'b1;
            st_next.run_cnt = 12'h000;
            loss_rise = 1'b1;
          end else begin
            st_next.run_cnt = st_reg.run_cnt + 12'h001;
          end
        end else begin
          st_next.run_cnt = 12'h000;
        end
      end else begin
        if (level_above_clr) begin
          if (st_reg.run_cnt + 12'h001 >= release_target) begin
            st_next.loss_state = 1'b0;
            st_next.run_cnt = 12'h000;
          end else begin
            st_next.run_cnt = st_reg.run_cnt + 12'h001;
          end
        end else begin
          st_next.run_cnt = 12'h000;
        end
      end
    end

    // A status read clears the event, but a rise in the same cycle is kept.
    if (rd_pulse && !test_space && bus_in.addr == LLEC_ADDR_STATUS) begin
      st_next.loss_event = 1'b0;
    end
    if (loss_rise) begin
      st_next.loss_event = 1'b1;
    end

    if (line_tick) begin
      st_next.div_cnt = loop_tick ? 9'h000 : st_reg.div_cnt + 9'h001;
    end

    // Loss counter steps once per loop period and drives the RAM read address.
    if (loop_tick) begin
      if (loss_step_up && !loss_step_down && st_reg.counter != 8'hff) begin
        st_next.counter = st_reg.counter + 8'h01;
      end else if (loss_step_down && !loss_step_up && st_reg.counter != 8'h00) begin
        st_next.counter = st_reg.counter - 8'h01;
      end
      if (delta > LLEC_SETTLE_STEP) begin
        st_next.ref_val = st_reg.counter;
        st_next.stable_cnt = 10'h000;
        st_next.settled = 1'b0;
      end else begin
        if (st_reg.stable_cnt != 10'h3ff) begin
          st_next.stable_cnt = st_reg.stable_cnt + 10'h001;
        end
        st_next.settled = (st_reg.stable_cnt >= window);
      end
    end

    if (st_reg.ram_load) begin
      st_next.data = ram_rdata;
    end

    if (wr_pulse && !test_space) begin
      if (bus_in.addr >= LLEC_ADDR_DATA0 && bus_in.addr <= LLEC_ADDR_DATA3) begin
        st_next.data[data_idx] = bus_in.wdata;
      end
      case (bus_in.addr)
        LLEC_ADDR_ASSERT: st_next.assert_iv = bus_in.wdata;
        LLEC_ADDR_RELEASE: st_next.release_iv = bus_in.wdata;
        LLEC_ADDR_POINTER: begin
          st_next.pointer = bus_in.wdata;
          ram_en = 1'b1;
          ram_addr = bus_in.wdata;
          ram_we = !st_reg.read_not_write;
          st_next.ram_load = st_reg.read_not_write;
        end
        LLEC_ADDR_DIR: st_next.read_not_write = bus_in.wdata[LLEC_DIR_BIT];
        LLEC_ADDR_COUNTER: begin
          st_next.counter = bus_in.wdata;
        end
        LLEC_ADDR_CONFIG: st_next.config_val = bus_in.wdata & LLEC_CFG_MASK;
        default: st_next.pointer = st_next.pointer;
      endcase
    end

    if (rd_pulse) begin
      st_next.rd_data = read_mux;
    end

    if (receive_unit_hold) begin
      st_next = LLEC_STATE_RESET;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= LLEC_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Test forcing bits keep whatever they hold across reset by design.
  always_ff @(posedge clock) begin
    if (wr_pulse && bus_in.addr == LLEC_ADDR_TEST_IO) begin
      test_force_reg <= bus_in.wdata;
    end
  end

  llec_eq_ram u_ram (
    .clock(clock),
    .rst(rst),
    .host_en(ram_en),
    .host_we(ram_we),
    .host_addr(ram_addr),
    .host_wdata(ram_wdata),
    .host_rdata(ram_rdata),
    .coef_addr(st_reg.counter),
    .coef_rdata(eq_coeff)
  );

  assign outputs_hiz = !bus_in.chip_select_n && !bus_in.read_strobe_n
    && !bus_in.write_strobe_n;
  assign bus_data_oe = rd_now && !outputs_hiz;
  assign bus_rd_data = st_reg.rd_data;
  // Forcing is gated by test mode, so an unknown force value never leaks in normal use.
  assign analog_signal_loss = test_mode0 ? test_force_reg[0] : st_reg.loss_state;
  assign equalizer_settled = test_mode0 ? test_force_reg[1] : st_reg.settled;
endmodule

// [src/llec_pkg.sv]
// Purpose: Shared constants and carriers for the line loss and equalizer control block.
// Assumes: 10 MHz system clock; line-rate and pulse-interval ticks arrive as enables.
// Notes: One aligned byte register per offset on a 9-bit parallel host bus.
// Contract
// - Receive unit hold forces every register to reset value while high; code leaves the test forcing bits unheld.
// - Declare signal loss after assert interval times 16 low pulse intervals.
// - Clear signal loss after release interval times 16 high pulse intervals.
// - Writing the RAM pointer starts a RAM read or write cycle.
// - Write access copies four indirect data registers into addressed RAM word.
// - Read access loads addressed RAM word into four indirect data registers.
// - Direction bit one means RAM read, zero means write; resets to one.
// - Host write to read counter overwrites the 8-bit RAM read address.
// - Host read of read counter returns the live counter value.
// - Three-bit loop rate field sets equalizer feedback rate per table.
// - Settled window code selects 32, 64, 128 or 256 loop periods.
// - Chip select, read and write strobes together tri-state all outputs.
// - Test-mode registers decode in their own address range 100h-1ffh.
// - Unused bit writes do nothing; reads vary, so software masks them.
// - Writable test-mode bits are not initialised by reset.
// - In test mode 0 host reads input levels and forces outputs.
// - Settled flag asserts when estimate moved at most 8 steps beyond window.
// - Loss event sets on loss state rise, clears on status read.
package llec_pkg;
  localparam logic [8:0] LLEC_ADDR_DATA0 = 9'h0d8;
  localparam logic [8:0] LLEC_ADDR_DATA3 = 9'h0db;
  localparam logic [8:0] LLEC_ADDR_STATUS = 9'h0f8;
  localparam logic [8:0] LLEC_ADDR_ASSERT = 9'h0fa;
  localparam logic [8:0] LLEC_ADDR_RELEASE = 9'h0fb;
  localparam logic [8:0] LLEC_ADDR_POINTER = 9'h0fc;
  localparam logic [8:0] LLEC_ADDR_DIR = 9'h0fd;
  localparam logic [8:0] LLEC_ADDR_COUNTER = 9'h0fe;
  localparam logic [8:0] LLEC_ADDR_CONFIG = 9'h0ff;
  localparam logic [8:0] LLEC_ADDR_TEST_IO = 9'h100;
  localparam int LLEC_STAT_EVENT_BIT = 7;
  localparam int LLEC_STAT_STATE_BIT = 6;
  localparam int LLEC_STAT_SETTLED_BIT = 2;
  localparam int LLEC_DIR_BIT = 7;
  localparam int LLEC_CFG_RATE_LSB = 0;
  localparam int LLEC_CFG_RESERVED_BIT = 3;
  localparam int LLEC_CFG_WIN_LSB = 6;
  localparam logic [7:0] LLEC_CFG_MASK = 8'hcf;
  localparam logic [7:0] LLEC_INTERVAL_RESET = 8'h00;
  localparam logic [7:0] LLEC_CONFIG_RESET = 8'h00;
  localparam logic [7:0] LLEC_POINTER_RESET = 8'h00;
  localparam logic [7:0] LLEC_COUNTER_RESET = 8'h00;
  localparam logic LLEC_DIR_RESET = 1'b1;
  // Log2 of the pulse intervals per unit of an interval register.
  localparam logic [3:0] LLEC_INTERVAL_UNIT_LOG2 = 4'h4;
  // Line ticks per loop period at rate code 0; code n divides by (n+1) times this.
  localparam logic [8:0] LLEC_LOOP_BASE_TICKS = 9'h040;
  localparam logic [8:0] LLEC_SETTLE_STEP = 9'h008;
  localparam logic [9:0] LLEC_WIN_32 = 10'h020;
  localparam logic [9:0] LLEC_WIN_64 = 10'h040;
  localparam logic [9:0] LLEC_WIN_128 = 10'h080;
  localparam logic [9:0] LLEC_WIN_256 = 10'h100;

  typedef struct packed {
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [8:0] addr;
    logic [7:0] wdata;
  } llec_bus_s;

  typedef struct packed {
    logic [7:0] assert_iv;
    logic [7:0] release_iv;
    logic [7:0] pointer;
    logic read_not_write;
    logic [7:0] counter;
    logic [7:0] config_val;
    logic [3:0][7:0] data;
    logic loss_state;
    logic loss_event;
    logic settled;
    logic [11:0] run_cnt;
    logic [8:0] div_cnt;
    logic [7:0] ref_val;
    logic [9:0] stable_cnt;
    logic wr_prev;
    logic rd_prev;
    logic ram_load;
    logic [7:0] rd_data;
  } llec_state_s;

  localparam llec_state_s LLEC_STATE_RESET = '{
    assert_iv: LLEC_INTERVAL_RESET, release_iv: LLEC_INTERVAL_RESET,
    pointer: LLEC_POINTER_RESET, read_not_write: LLEC_DIR_RESET,
    counter: LLEC_COUNTER_RESET, config_val: LLEC_CONFIG_RESET,
    data: '0, loss_state: 1'b0, loss_event: 1'b0, settled: 1'b0,
    run_cnt: '0, div_cnt: '0, ref_val: '0, stable_cnt: '0,
    wr_prev: 1'b0, rd_prev: 1'b0, ram_load: 1'b0, rd_data: 8'h00};
endpackage

// [src/llec_eq_ram.sv]
// Purpose: 256-word equalizer RAM with a host port and a coefficient read port.
// Assumes: Both read ports return data one clock after the address.
// Notes: Storage has no reset; only the read registers are cleared.
`timescale 1ns/1ns
module llec_eq_ram
  import llec_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic host_en, // Host access strobe.
  input wire logic host_we, // Host write when high.
  input wire logic [7:0] host_addr, // Host word address.
  input wire logic [31:0] host_wdata, // Host write word.
  output logic [31:0] host_rdata, // Host read word, registered.
  input wire logic [7:0] coef_addr, // Coefficient read address.
  output logic [31:0] coef_rdata // Coefficient word, registered.
);
  logic [31:0] mem [0:255];

  always_ff @(posedge clock) begin
    if (host_en && host_we) begin
      mem[host_addr] <= host_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      host_rdata <= 32'h0;
      coef_rdata <= 32'h0;
    end else begin
      if (host_en && !host_we) begin
        host_rdata <= mem[host_addr];
      end
      coef_rdata <= mem[coef_addr];
    end
  end
endmodule

// [dv/llec_top_properties.sv]
// Purpose: Port-level properties of the line loss and equalizer control block.
// Assumes: One clock domain with an asynchronous active-high reset.
// Notes: Test mode 0 overrides the status outputs, so loss and settle checks skip it.
`timescale 1ns/1ns
module llec_top_properties
  import llec_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst, // Reset.
  input wire logic receive_unit_hold, // Register hold.
  input wire llec_bus_s bus_in, // Host bus.
  input wire logic [7:0] bus_rd_data, // Read data.
  input wire logic bus_data_oe, // Data bus enable.
  input wire logic outputs_hiz, // Float indication.
  input wire logic pulse_tick, // Pulse interval tick.
  input wire logic level_below_det, // Below detection.
  input wire logic level_above_clr, // Above clearance.
  input wire logic test_mode0, // Test mode 0.
  input wire logic analog_signal_loss, // Loss state.
  input wire logic equalizer_settled, // Settled flag.
  input wire logic loop_tick // Loop period tick.
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic rd_lvl;
  assign rd_lvl = !bus_in.chip_select_n && !bus_in.read_strobe_n && bus_in.write_strobe_n;
  sequence rd_start;
    rd_lvl && !$past(rd_lvl);
  endsequence
  sequence no_test;
    !test_mode0 && !$past(test_mode0);
  endsequence
  hiz_decode_a: assert property (outputs_hiz == (!bus_in.chip_select_n &&
    !bus_in.read_strobe_n && !bus_in.write_strobe_n)) else $error("float indication wrong");
  hiz_oe_a: assert property (outputs_hiz |-> !bus_data_oe) else $error("data bus driven");
  read_oe_a: assert property (rd_lvl |-> bus_data_oe) else $error("read not driven");
  hold_clears_a: assert property (receive_unit_hold && $past(receive_unit_hold) &&
    !test_mode0 |-> !analog_signal_loss && !equalizer_settled) else $error("hold ignored");
  loss_rise_a: assert property (no_test ##0 $rose(analog_signal_loss) |->
    $past(pulse_tick && level_below_det)) else $error("loss set without low pulse");
  loss_fall_a: assert property (no_test ##0 ($fell(analog_signal_loss) &&
    !$past(receive_unit_hold)) |-> $past(pulse_tick && level_above_clr)) else $error("bad clear");
  settle_tick_a: assert property (no_test ##0 $rose(equalizer_settled) |->
    $past(loop_tick)) else $error("settled off loop tick");
  test_space_a: assert property (rd_start ##0 (bus_in.addr[8] &&
    bus_in.addr != LLEC_ADDR_TEST_IO) |=> bus_rd_data == 8'h00) else $error("test read");
  dir_unused_a: assert property (rd_start ##0 (bus_in.addr == LLEC_ADDR_DIR) |=>
    bus_rd_data[6:0] == 7'h00) else $error("unused bits set");
endmodule
bind llec_top llec_top_properties llec_top_properties_i (.clock(clock), .rst(rst),
  .receive_unit_hold(receive_unit_hold), .bus_in(bus_in), .bus_rd_data(bus_rd_data),
  .bus_data_oe(bus_data_oe), .outputs_hiz(outputs_hiz), .pulse_tick(pulse_tick),
  .level_below_det(level_below_det), .level_above_clr(level_above_clr),
  .test_mode0(test_mode0), .analog_signal_loss(analog_signal_loss),
  .equalizer_settled(equalizer_settled), .loop_tick(loop_tick));

// [dv/llec_host.sv]
// Purpose: Microprocessor model on the parallel register bus.
// Assumes: Strobes are taken on the first edge they are seen low.
// Notes: Each access leaves one idle cycle; released lines carry inverted garbage.
`timescale 1ns/1ns
module llec_host
  import llec_pkg::*;
(
  input wire logic clock, // System clock.
  output llec_bus_s bus_o, // Host bus strobes, address and data.
  input wire logic [7:0] rd_data // Read data.
);
  initial bus_o = '{1'b1, 1'b1, 1'b1, 9'h000, 8'h00};
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 bus_o = '{1'b0, 1'b1, 1'b0, a, d};
    @(posedge clock);
    #1 bus_o = '{1'b1, 1'b1, 1'b1, ~a, ~d};
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clock);
    #1 bus_o = '{1'b0, 1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    #1 d = rd_data;
    bus_o = '{1'b1, 1'b1, 1'b1, ~a, 8'hff};
  endtask
  // The caller samples the float outputs itself, since task inputs are frozen at the call.
  task automatic float_all(input logic hold_low);
    @(posedge clock);
    #1;
    if (hold_low) begin
      bus_o = '{1'b0, 1'b0, 1'b0, LLEC_ADDR_TEST_IO, 8'h00};
    end else begin
      bus_o = '{1'b1, 1'b1, 1'b1, 9'h000, 8'h00};
    end
  endtask
endmodule

// [dv/tb_llec_top.sv]
// Purpose: Self-checking bench for the line loss and equalizer control block.
// Assumes: Line tick every second clock, so one loop period is 128 clocks at code 0.
// Notes: Each scenario task drives the block and judges the answer itself.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_llec_top;
  import llec_pkg::*;
  logic clock = 1'b0, rst = 1'b1, receive_unit_hold = 1'b0, pulse_tick = 1'b0;
  logic level_below_det = 1'b0, level_above_clr = 1'b0, line_tick = 1'b0;
  logic loss_step_up = 1'b0, loss_step_down = 1'b0, test_mode0 = 1'b0;
  logic bus_data_oe, outputs_hiz, analog_signal_loss, equalizer_settled, loop_tick;
  logic [7:0] bus_rd_data, rd;
  logic [1:0] hz;
  logic [31:0] eq_coeff;
  llec_bus_s bus_in;
  int error_cnt = 0, n_checks = 0, t;
  always #50 clock = ~clock;
  always @(posedge clock) #1 line_tick = ~line_tick;
  llec_top llec_top_i (.clock(clock), .rst(rst), .receive_unit_hold(receive_unit_hold),
    .bus_in(bus_in), .bus_rd_data(bus_rd_data), .bus_data_oe(bus_data_oe),
    .outputs_hiz(outputs_hiz), .pulse_tick(pulse_tick), .level_below_det(level_below_det),
    .level_above_clr(level_above_clr), .line_tick(line_tick), .loss_step_up(loss_step_up),
    .loss_step_down(loss_step_down), .test_mode0(test_mode0),
    .analog_signal_loss(analog_signal_loss), .equalizer_settled(equalizer_settled),
    .eq_coeff(eq_coeff), .loop_tick(loop_tick));
  llec_host llec_host_i (.clock(clock), .bus_o(bus_in), .rd_data(bus_rd_data));
  task automatic results();
    $display("Checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic loops(input int n);
    for (int k = 0; k < n; k++) begin
      t = 0;
      // Sampled on the falling edge, where the line tick and the divider have both settled.
      do begin @(negedge clock); t++; end while (loop_tick !== 1'b1 && t < 2000);
      if (t >= 2000) begin error_cnt++; $display("Error loop tick missing"); results(); end
    end
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      #1 pulse_tick = 1'b1;
      @(posedge clock);
      #1 pulse_tick = 1'b0;
    end
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      llec_host_i.rd(LLEC_ADDR_ASSERT + 9'(i), rd);
      `CHK("reset value", (i == 3) ? 8'h80 : 8'h00, rd)
    end
    $display("test reset done");
  endtask
  task automatic t_hold();
    llec_host_i.wr(LLEC_ADDR_ASSERT, 8'h33);
    llec_host_i.wr(LLEC_ADDR_DIR, 8'h00);
    receive_unit_hold = 1'b1;
    llec_host_i.wr(LLEC_ADDR_RELEASE, 8'h44);
    receive_unit_hold = 1'b0;
    llec_host_i.rd(LLEC_ADDR_ASSERT, rd);
    `CHK("held assert", 8'h00, rd)
    llec_host_i.rd(LLEC_ADDR_RELEASE, rd);
    `CHK("held release", 8'h00, rd)
    llec_host_i.rd(LLEC_ADDR_DIR, rd);
    `CHK("held direction", 8'h80, rd)
    $display("test hold done");
  endtask
  task automatic t_ram();
    for (int i = 0; i < 4; i++) llec_host_i.wr(LLEC_ADDR_DATA0 + 9'(i), 8'ha0 + 8'(i));
    llec_host_i.wr(LLEC_ADDR_DIR, 8'h00);
    llec_host_i.wr(LLEC_ADDR_POINTER, 8'h05);
    repeat (8) @(posedge clock);
    for (int i = 0; i < 4; i++) llec_host_i.wr(LLEC_ADDR_DATA0 + 9'(i), 8'h00);
    llec_host_i.wr(LLEC_ADDR_DIR, 8'h80);
    llec_host_i.wr(LLEC_ADDR_POINTER, 8'h05);
    repeat (8) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      llec_host_i.rd(LLEC_ADDR_DATA0 + 9'(i), rd);
      `CHK("ram byte", 8'ha0 + 8'(i), rd)
    end
    llec_host_i.wr(LLEC_ADDR_COUNTER, 8'h05);
    repeat (3) @(posedge clock);
    #1;
    `CHK("coefficient", 32'ha3a2a1a0, eq_coeff)
    $display("test ram done");
  endtask
  task automatic t_loss();
    llec_host_i.wr(LLEC_ADDR_ASSERT, 8'h01);
    llec_host_i.wr(LLEC_ADDR_RELEASE, 8'h01);
    level_below_det = 1'b1;
    pulses(8);
    level_below_det = 1'b0;
    pulses(1);
    level_below_det = 1'b1;
    pulses(15);
    `CHK("loss early", 1'b0, analog_signal_loss)
    pulses(1);
    `CHK("loss set", 1'b1, analog_signal_loss)
    llec_host_i.rd(LLEC_ADDR_STATUS, rd);
    `CHK("event set", 1'b1, rd[7])
    llec_host_i.rd(LLEC_ADDR_STATUS, rd);
    `CHK("event cleared", 2'b01, rd[7:6])
    level_below_det = 1'b0;
    level_above_clr = 1'b1;
    pulses(15);
    `CHK("loss held", 1'b1, analog_signal_loss)
    pulses(1);
    `CHK("loss cleared", 1'b0, analog_signal_loss)
    level_above_clr = 1'b0;
    $display("test loss done");
  endtask
  task automatic t_loop();
    llec_host_i.wr(LLEC_ADDR_CONFIG, 8'h08);
    llec_host_i.wr(LLEC_ADDR_COUNTER, 8'h7f);
    llec_host_i.rd(LLEC_ADDR_COUNTER, rd);
    `CHK("counter write", 8'h7f, rd)
    // Align to a loop tick first so that exactly ten steps are taken.
    loops(1);
    @(posedge clock);
    #1 loss_step_up = 1'b1;
    loops(10);
    repeat (2) @(posedge clock);
    #1 loss_step_up = 1'b0;
    llec_host_i.rd(LLEC_ADDR_COUNTER, rd);
    `CHK("live counter", 8'h89, rd)
    loops(25);
    `CHK("not settled", 1'b0, equalizer_settled)
    loops(10);
    `CHK("settled", 1'b1, equalizer_settled)
    for (int c = 0; c < 8; c++) begin
      llec_host_i.wr(LLEC_ADDR_CONFIG, 8'h08 | 8'(c));
      loops(3);
      `CHK("loop period", 128 * (c + 1), t)
    end
    $display("test loop done");
  endtask
  task automatic t_misc();
    llec_host_i.float_all(1'b1);
    #10 hz = {outputs_hiz, bus_data_oe};
    llec_host_i.float_all(1'b0);
    `CHK("float", 2'b10, hz)
    llec_host_i.rd(9'h150, rd);
    `CHK("test space", 8'h00, rd)
    llec_host_i.wr(LLEC_ADDR_DIR, 8'h7f);
    llec_host_i.rd(LLEC_ADDR_DIR, rd);
    `CHK("direction masked", 8'h00, rd)
    test_mode0 = 1'b1;
    llec_host_i.wr(LLEC_ADDR_TEST_IO, 8'h03);
    `CHK("forced outputs", 2'b11, {analog_signal_loss, equalizer_settled})
    level_below_det = 1'b1;
    llec_host_i.rd(LLEC_ADDR_TEST_IO, rd);
    `CHK("observed inputs", 2'b01, rd[1:0])
    llec_host_i.wr(LLEC_ADDR_TEST_IO, 8'h00);
    test_mode0 = 1'b0;
    level_below_det = 1'b0;
    $display("test misc done");
  endtask
  initial begin
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    t_reset();
    t_hold();
    t_ram();
    t_loss();
    t_loop();
    t_misc();
    results();
  end
endmodule
